// ### rtl/lane_link_status.v
// lane 6 and 7 link status flags with axi4-lite register access and interrupt
//
// Summary of operation
// - bad-disparity flag is 1 when its error count is at or above threshold
// - invalid-symbol flag is 1 when its error count reaches the threshold
// - unexpected control char flag is 1 when its count is at or above threshold
// - bit 4 reads 1 when interlane deskew achieved, 0 when failed
// - bit 3 reads 1 when initial lane alignment sync achieved, 0 when lost
// - bit 2 reads 1 when received alignment checksum is correct
// - bit 1 reads 1 while frame sync achieved, 0 when lost
// - bit 0 reads 1 while code group sync achieved, 0 when lost
// - lane status reads return the copy of the link chosen by the page register
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "lane_status_consts.vh"

module lane_link_status
(
	// clock and reset
	input  wire        sys_clk_i,
	input  wire        srst_i,
	// receiver lane state, link 0 in low half, link 1 in high half
	input  wire [15:0] lane6_bad_disparity_cnt_i,
	input  wire [15:0] lane6_invalid_symbol_cnt_i,
	input  wire [15:0] lane6_unexpected_control_char_cnt_i,
	input  wire [9:0]  lane6_sync_state_i,
	input  wire [15:0] lane7_bad_disparity_cnt_i,
	input  wire [15:0] lane7_invalid_symbol_cnt_i,
	input  wire [15:0] lane7_unexpected_control_char_cnt_i,
	input  wire [9:0]  lane7_sync_state_i,
	input  wire [7:0]  error_count_threshold_i,
	// axi4-lite write channels
	input  wire [15:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	// axi4-lite read channels
	input  wire [15:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	// interrupt
	output wire        irq_o
);

	// builds one status byte from counts, threshold and sync state
	function [7:0] flag_byte;
		input [7:0] disp_cnt;
		input [7:0] sym_cnt;
		input [7:0] ctrl_cnt;
		input [7:0] thr;
		input [4:0] st;
		begin
			flag_byte                          = `FLAGS_RESET;
			flag_byte[`BAD_DISPARITY_BIT]      = (disp_cnt >= thr);
			flag_byte[`INVALID_SYMBOL_BIT]     = (sym_cnt >= thr);
			flag_byte[`UNEXPECTED_CTRL_BIT]    = (ctrl_cnt >= thr);
			flag_byte[`DESKEW_OK_BIT]          = st[`ST_DESKEW];
			flag_byte[`INITIAL_ALIGN_OK_BIT]   = st[`ST_INITIAL_ALIGN];
			flag_byte[`CHECKSUM_OK_BIT]        = st[`ST_CHECKSUM];
			flag_byte[`FRAME_SYNC_OK_BIT]      = st[`ST_FRAME_SYNC];
			flag_byte[`CODE_GROUP_SYNC_OK_BIT] = st[`ST_CODE_GROUP_SYNC];
		end
	endfunction

	// maps a byte address to a register select code
	function [2:0] reg_sel;
		input [15:0] addr;
		begin
			if (addr == (`LINK_PAGE_IDX << 2))
				reg_sel = `SEL_PAGE;
			else if (addr == (`LANE6_LINK_STATUS_IDX << 2))
				reg_sel = `SEL_LANE6;
			else if (addr == (`LANE7_LINK_STATUS_IDX << 2))
				reg_sel = `SEL_LANE7;
			else if (addr == `IRQ_STATUS_ADDR)
				reg_sel = `SEL_IRQ_STATUS;
			else if (addr == `IRQ_MASK_ADDR)
				reg_sel = `SEL_IRQ_MASK;
			else
				reg_sel = `SEL_NONE;
		end
	endfunction

	// flag copies per link
	reg  [7:0]  lane6_l0_q;
	reg  [7:0]  lane6_l1_q;
	reg  [7:0]  lane7_l0_q;
	reg  [7:0]  lane7_l1_q;
	wire [7:0]  lane6_l0_d;
	wire [7:0]  lane6_l1_d;
	wire [7:0]  lane7_l0_d;
	wire [7:0]  lane7_l1_d;
	reg         link_page_q;
	reg  [15:0] irq_status_q;
	reg  [15:0] irq_status_d;
	reg  [15:0] irq_mask_q;
	reg         irq_q;
	wire [15:0] flag_event;

	// axi state
	reg         awready_q;
	reg         wready_q;
	reg         aw_held_q;
	reg         w_held_q;
	reg  [15:0] awaddr_q;
	reg  [31:0] wdata_q;
	reg  [3:0]  wstrb_q;
	reg         bvalid_q;
	reg  [1:0]  bresp_q;
	reg         arready_q;
	reg         rvalid_q;
	reg  [31:0] rdata_q;
	reg  [1:0]  rresp_q;
	wire        do_write;
	wire [2:0]  wsel;
	wire [2:0]  rsel;
	reg  [31:0] rd_word;

	assign lane6_l0_d = flag_byte(lane6_bad_disparity_cnt_i[7:0],
		lane6_invalid_symbol_cnt_i[7:0], lane6_unexpected_control_char_cnt_i[7:0],
		error_count_threshold_i, lane6_sync_state_i[4:0]);
	assign lane6_l1_d = flag_byte(lane6_bad_disparity_cnt_i[15:8],
		lane6_invalid_symbol_cnt_i[15:8], lane6_unexpected_control_char_cnt_i[15:8],
		error_count_threshold_i, lane6_sync_state_i[9:5]);
	assign lane7_l0_d = flag_byte(lane7_bad_disparity_cnt_i[7:0],
		lane7_invalid_symbol_cnt_i[7:0], lane7_unexpected_control_char_cnt_i[7:0],
		error_count_threshold_i, lane7_sync_state_i[4:0]);
	assign lane7_l1_d = flag_byte(lane7_bad_disparity_cnt_i[15:8],
		lane7_invalid_symbol_cnt_i[15:8], lane7_unexpected_control_char_cnt_i[15:8],
		error_count_threshold_i, lane7_sync_state_i[9:5]);

	// flags follow the receiver only; bus writes never reach them
	always @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			lane6_l0_q <= `FLAGS_RESET;
			lane6_l1_q <= `FLAGS_RESET;
			lane7_l0_q <= `FLAGS_RESET;
			lane7_l1_q <= `FLAGS_RESET;
		end
		else
		begin
			lane6_l0_q <= lane6_l0_d;
			lane6_l1_q <= lane6_l1_d;
			lane7_l0_q <= lane7_l0_d;
			lane7_l1_q <= lane7_l1_d;
		end
	end

	// any flag change on either link is an event; lane 6 low byte, lane 7 high byte
	assign flag_event = {(lane7_l0_d ^ lane7_l0_q) | (lane7_l1_d ^ lane7_l1_q),
		(lane6_l0_d ^ lane6_l0_q) | (lane6_l1_d ^ lane6_l1_q)};

	// write path: address and data taken in either order
	assign do_write = aw_held_q && w_held_q && !bvalid_q;
	assign wsel     = reg_sel(awaddr_q);
	assign rsel     = reg_sel(s_axi_araddr);

	always @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			awaddr_q  <= 16'h0000;
			wdata_q   <= 32'h00000000;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `RESP_OKAY;
		end
		else
		begin
			awready_q <= !aw_held_q && !(s_axi_awvalid && awready_q) && !bvalid_q;
			wready_q  <= !w_held_q && !(s_axi_wvalid && wready_q) && !bvalid_q;
			if (s_axi_awvalid && awready_q)
			begin
				aw_held_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wready_q)
			begin
				w_held_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_held_q <= 1'b0;
				w_held_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= (wsel == `SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
			end
			else if (bvalid_q && s_axi_bready)
				bvalid_q <= 1'b0;
		end
	end

	// page selector, interrupt mask
	always @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			link_page_q <= `PAGE_RESET;
			irq_mask_q  <= `IRQ_RESET;
		end
		else if (do_write)
		begin
			if (wsel == `SEL_PAGE && wstrb_q[0])
				link_page_q <= wdata_q[0];
			if (wsel == `SEL_IRQ_MASK && wstrb_q[0])
				irq_mask_q[7:0] <= wdata_q[7:0];
			if (wsel == `SEL_IRQ_MASK && wstrb_q[1])
				irq_mask_q[15:8] <= wdata_q[15:8];
		end
	end

	// sticky status, write one to clear; a new event wins over the clear
	always @*
	begin
		irq_status_d = irq_status_q;
		if (do_write && wsel == `SEL_IRQ_STATUS)
		begin
			if (wstrb_q[0])
				irq_status_d[7:0] = irq_status_q[7:0] & ~wdata_q[7:0];
			if (wstrb_q[1])
				irq_status_d[15:8] = irq_status_q[15:8] & ~wdata_q[15:8];
		end
		irq_status_d = irq_status_d | flag_event;
	end

	always @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			irq_status_q <= `IRQ_RESET;
			irq_q        <= 1'b0;
		end
		else
		begin
			irq_status_q <= irq_status_d;
			irq_q        <= |(irq_status_d & irq_mask_q);
		end
	end

	// read data mux; lane status reads show the paged copy, irq status covers both links
	always @*
	begin
		rd_word = 32'h00000000;
		case (rsel)
			`SEL_PAGE:
				rd_word[0] = link_page_q;
			`SEL_LANE6:
				rd_word[7:0] = link_page_q ? lane6_l1_q : lane6_l0_q;
			`SEL_LANE7:
				rd_word[7:0] = link_page_q ? lane7_l1_q : lane7_l0_q;
			`SEL_IRQ_STATUS:
				rd_word[15:0] = irq_status_q;
			`SEL_IRQ_MASK:
				rd_word[15:0] = irq_mask_q;
			default:
				rd_word = 32'h00000000;
		endcase
	end

	// read path
	always @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h00000000;
			rresp_q   <= `RESP_OKAY;
		end
		else
		begin
			arready_q <= !rvalid_q && !(s_axi_arvalid && arready_q);
			if (s_axi_arvalid && arready_q)
			begin
				rvalid_q <= 1'b1;
				rdata_q  <= rd_word;
				rresp_q  <= (rsel == `SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
			end
			else if (rvalid_q && s_axi_rready)
				rvalid_q <= 1'b0;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign irq_o         = irq_q;

endmodule // lane_link_status

// ### rtl/lane_status_consts.vh
// register map, field positions and reset values of the lane link status block
`ifndef LANE_STATUS_CONSTS_VH
`define LANE_STATUS_CONSTS_VH

// register indices; byte address is four times the index
`define LINK_PAGE_IDX          16'h0300
`define LANE6_LINK_STATUS_IDX  16'h04b6
`define LANE7_LINK_STATUS_IDX  16'h04b7
// interrupt registers, byte addresses
`define IRQ_STATUS_ADDR        16'h1400
`define IRQ_MASK_ADDR          16'h1404

// register select codes
`define SEL_NONE               3'h0
`define SEL_PAGE               3'h1
`define SEL_LANE6              3'h2
`define SEL_LANE7              3'h3
`define SEL_IRQ_STATUS         3'h4
`define SEL_IRQ_MASK           3'h5

// status byte field positions
`define BAD_DISPARITY_BIT      7
`define INVALID_SYMBOL_BIT     6
`define UNEXPECTED_CTRL_BIT    5
`define DESKEW_OK_BIT          4
`define INITIAL_ALIGN_OK_BIT   3
`define CHECKSUM_OK_BIT        2
`define FRAME_SYNC_OK_BIT      1
`define CODE_GROUP_SYNC_OK_BIT 0

// sync state input layout per link (5 bits)
`define ST_DESKEW              4
`define ST_INITIAL_ALIGN       3
`define ST_CHECKSUM            2
`define ST_FRAME_SYNC          1
`define ST_CODE_GROUP_SYNC     0

// reset values
`define FLAGS_RESET            8'h00
`define PAGE_RESET             1'b0
`define IRQ_RESET              16'h0000

// axi responses
`define RESP_OKAY              2'b00
`define RESP_SLVERR            2'b10

`endif

// ### tb/lane_link_status_properties.sv
// assertion checker for the lane link status block
`timescale 1ns/1ps
module lane_link_status_props(
	input wire        sys_clk_i, srst_i, irq_o,
	input wire        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
	input wire        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
	input wire        s_axi_rvalid, s_axi_rready,
	input wire [1:0]  s_axi_bresp, s_axi_rresp,
	input wire [31:0] s_axi_rdata
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	rd_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answered twice");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
		else $error("error read carries data");
	rst_quiet_a: assert property ($past(srst_i) |->
		!irq_o && !s_axi_rvalid && !s_axi_bvalid)
		else $error("outputs not cleared by reset");
	cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
	cover property ($rose(irq_o));
	cover property (s_axi_bvalid && s_axi_bready);
endmodule // lane_link_status_props

bind lane_link_status lane_link_status_props chk (
	.sys_clk_i(sys_clk_i), .srst_i(srst_i), .irq_o(irq_o),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_bresp(s_axi_bresp), .s_axi_rresp(s_axi_rresp),
	.s_axi_rdata(s_axi_rdata));

// ### tb/lane_tx_model.sv
// far-side transmitter model: drives lane error counts and sync state
`timescale 1ns/1ps
module lane_tx_model(
	input  wire         sys_clk_i,
	output reg  [115:0] rx_o
);
	initial rx_o = 116'h0;
	// new lane state lands just after an edge, after a chosen idle spell
	task automatic send(input int gap, input [115:0] v);
		repeat (gap) @(posedge sys_clk_i);
		rx_o <= v;
	endtask
endmodule // lane_tx_model

// ### tb/testbench.sv
// self-checking bench for the lane link status block
`timescale 1ns/1ps
`include "lane_status_consts.vh"
module testbench;
	localparam [15:0] pg_a = `LINK_PAGE_IDX << 2;
	localparam [15:0] l6_a = `LANE6_LINK_STATUS_IDX << 2;
	localparam [15:0] l7_a = `LANE7_LINK_STATUS_IDX << 2;
	reg          sys_clk_i = 1'h0, srst_i = 1'h1;
	// threshold starts above every count so all flags read zero after reset
	reg  [7:0]   thr = 8'hff;
	reg  [3:0]   wstrb = 4'hf;
	reg  [15:0]  awaddr = 16'h0, araddr = 16'h0;
	reg  [31:0]  wdata = 32'h0;
	reg          awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	wire         awready, wready, bvalid, arready, rvalid, irq;
	wire [1:0]   bresp, rresp;
	wire [31:0]  rdata;
	wire [115:0] rx;
	reg  [115:0] v;
	reg  [33:0]  rq[$];
	reg  [1:0]   bq[$];
	reg          pg;
	int          n_fail = 0, checked = 0, cyc = 0;
	always #50 sys_clk_i = ~sys_clk_i;
	lane_tx_model tx(.sys_clk_i(sys_clk_i), .rx_o(rx));
	lane_link_status dut(
		.sys_clk_i(sys_clk_i), .srst_i(srst_i),
		.lane6_bad_disparity_cnt_i(rx[57:42]), .lane6_invalid_symbol_cnt_i(rx[41:26]),
		.lane6_unexpected_control_char_cnt_i(rx[25:10]), .lane6_sync_state_i(rx[9:0]),
		.lane7_bad_disparity_cnt_i(rx[115:100]), .lane7_invalid_symbol_cnt_i(rx[99:84]),
		.lane7_unexpected_control_char_cnt_i(rx[83:68]), .lane7_sync_state_i(rx[67:58]),
		.error_count_threshold_i(thr), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_o(irq));
	// expected status byte of one lane for one link copy
	function [7:0] fl(input [57:0] x, input p);
		fl = {x[42+8*p+:8] >= thr, x[26+8*p+:8] >= thr, x[10+8*p+:8] >= thr, x[5*p+:5]};
	endfunction
	task cmp_rd(input [33:0] g, input [33:0] e);
		checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("[FAIL] %0t read got %h want %h", $time, g, e);
		end
	endtask
	task cmp_wr(input [1:0] g, input [1:0] e);
		checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("[FAIL] %0t write response got %h want %h", $time, g, e);
		end
	endtask
	// irq is a level: look at it mid-cycle, then resume on a rising edge
	task cmp_irq(input e);
		@(negedge sys_clk_i);
		checked++;
		if (irq !== e)
		begin
			n_fail++;
			$display("[FAIL] %0t irq got %b want %b", $time, irq, e);
		end
		@(posedge sys_clk_i);
	endtask
	task tally_and_finish;
		if (n_fail == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wr(input [15:0] a, input [31:0] d, input [1:0] e);
		bq.push_back(e);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		fork
			begin
				do @(posedge sys_clk_i); while (!awready);
				awvalid <= 1'h0;
			end
			begin
				do @(posedge sys_clk_i); while (!wready);
				wvalid <= 1'h0;
			end
		join
		do @(posedge sys_clk_i); while (!bvalid);
		bready <= 1'h0;
		@(posedge sys_clk_i);
	endtask
	task automatic rd(input [15:0] a, input [31:0] d, input [1:0] e);
		rq.push_back({e, d});
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do @(posedge sys_clk_i); while (!arready);
		arvalid <= 1'h0;
		do @(posedge sys_clk_i); while (!rvalid);
		rready <= 1'h0;
		@(posedge sys_clk_i);
	endtask
	// result watcher and hang limit
	always @(posedge sys_clk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			tally_and_finish;
		end
		if (rvalid && rready)
			cmp_rd({rresp, rdata}, rq.pop_front());
		if (bvalid && bready)
			cmp_wr(bresp, bq.pop_front());
	end
	initial
	begin
		void'($urandom(95));
		repeat (6) @(posedge sys_clk_i);
		srst_i <= 1'h0;
		@(posedge sys_clk_i);
		rd(l6_a, 32'h0, `RESP_OKAY);
		for (int i = 0; i < 16; i++)
		begin
			v = {$urandom, $urandom, $urandom, $urandom};
			thr <= v[49:42];
			// lane 7 link 0 sits one below the threshold, lane 6 link 0 right on it
			v[91:84] = v[49:42] - 8'h1;
			pg = v[100];
			tx.send(1, v);
			wr(pg_a, {31'h0, pg}, `RESP_OKAY);
			wr(l7_a, $urandom, `RESP_OKAY);
			rd(l6_a, {24'h0, fl(v[57:0], pg)}, `RESP_OKAY);
			rd(l7_a, {24'h0, fl(v[115:58], pg)}, `RESP_OKAY);
		end
		rd(pg_a, {31'h0, pg}, `RESP_OKAY);
		wr(16'h0010, 32'h1, `RESP_SLVERR);
		rd(16'h0010, 32'h0, `RESP_SLVERR);
		// only the low byte lane is enabled, so the mask keeps its upper byte
		wstrb <= 4'h1;
		wr(`IRQ_MASK_ADDR, 32'hffff, `RESP_OKAY);
		wstrb <= 4'hf;
		rd(`IRQ_MASK_ADDR, 32'h00ff, `RESP_OKAY);
		wr(`IRQ_MASK_ADDR, 32'h0, `RESP_OKAY);
		wr(`IRQ_STATUS_ADDR, 32'hffff, `RESP_OKAY);
		cmp_irq(1'h0);
		rd(`IRQ_STATUS_ADDR, 32'h0, `RESP_OKAY);
		wr(`IRQ_MASK_ADDR, 32'hffff, `RESP_OKAY);
		v[5] = ~v[5];
		tx.send(1, v);
		repeat (4) @(posedge sys_clk_i);
		cmp_irq(1'h1);
		rd(`IRQ_STATUS_ADDR, 32'h1, `RESP_OKAY);
		wr(`IRQ_MASK_ADDR, 32'h0, `RESP_OKAY);
		cmp_irq(1'h0);
		wr(`IRQ_STATUS_ADDR, 32'hffff, `RESP_OKAY);
		rd(`IRQ_STATUS_ADDR, 32'h0, `RESP_OKAY);
		tally_and_finish;
	end
endmodule // testbench
